// ### core/canip_top.v
`timescale 1ns/100ps
`default_nettype none
`include "canip_regs.vh"

// Contract
// - eight interrupt flags with a matching per-source enable register.
// - only the error flag has several causes; cause readable in comm status.
// - 3-bit pending code, lower is higher priority, zero means no coded source pending; the message error flag has no code.
// - pending code moves to the next pending source once the top is cleared.
// - only enabled sources take part in the pending code.
// - transmit flag set when its buffer becomes empty.
// - receive flag set when a message is loaded after end of frame.
// - any message error sets the message error flag; interrupt only if enabled.
// - bus activity during sleep with wake enabled sets wake flag and ends sleep.
// - error flag set on receive overflow or any error state change.
// - accepted message with its buffer still full sets a sticky overflow bit.
// - receiver warning when receive error counter reaches 96.
// - transmitter warning when transmit error counter reaches 96.
// - receiver error passive when receive error counter exceeds 127.
// - transmitter error passive when transmit error counter exceeds 127.
// - bus off when transmit error counter exceeds 255.
// - interrupt stays pending while any of its flags is set.
// - software clear is ignored while the setting condition is present.
module canip_top
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [2:0]  tx_buf_done,
   input  wire [1:0]  rx_frame_accepted,
   input  wire        msg_error_event,
   input  wire        bus_activity,
   input  wire [7:0]  rx_err_count,
   input  wire [8:0]  tx_err_count,
   output reg  [1:0]  rx_load,
   output reg  [2:0]  pending_source_code,
   output reg         sleep_mode,
   output reg         irq
);

   reg  [7:0]              irq_flag_reg;
   reg  [7:0]              irq_enable_reg;
   reg  [`CANIP_NERRST-1:0] err_state;
   reg  [1:0]              rx_overflow_bit;
   reg  [11:0]             wr_addr;
   reg  [7:0]              wr_data;
   reg                     wr_lane0;

   wire [7:0]              next_flag;
   reg  [7:0]              next_enable;
   reg  [1:0]              next_ovf;
   reg                     next_sleep;
   reg  [2:0]              next_code;
   wire [7:0]              next_pend;
   wire [7:0]              flag_set;
   wire [7:0]              flag_clr;
   wire [`CANIP_NERRST-1:0] live_err;
   wire                    err_changed;
   wire [1:0]              ovf_event;
   wire                    wake_event;
   wire                    wr_fire;
   wire [`CANIP_ADDR_W-1:0] wr_off;
   wire [`CANIP_ADDR_W-1:0] rd_off;
   wire                    wr_mapped;
   wire                    wr_flag;
   wire                    wr_enable;
   wire                    wr_state;
   wire                    wr_comm;
   wire [7:0]              module_state_reg;
   wire [7:0]              comm_status_reg;
   reg  [7:0]              rd_byte;
   reg                     rd_ok;

   // write address and data are latched independently, the write is done
   // once both are held and no response is outstanding
   assign wr_fire   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   assign wr_off    = wr_addr[`CANIP_ADDR_W-1:0];
   assign wr_mapped = (wr_addr[`CANIP_ADDR_HI:`CANIP_ADDR_W] == 8'h00) &&
                      ((wr_off == `CANIP_OFF_FLAG) || (wr_off == `CANIP_OFF_ENABLE) ||
                       (wr_off == `CANIP_OFF_STATE) || (wr_off == `CANIP_OFF_COMM));
   assign wr_flag   = wr_fire & wr_mapped & wr_lane0 & (wr_off == `CANIP_OFF_FLAG);
   assign wr_enable = wr_fire & wr_mapped & wr_lane0 & (wr_off == `CANIP_OFF_ENABLE);
   assign wr_state  = wr_fire & wr_mapped & wr_lane0 & (wr_off == `CANIP_OFF_STATE);
   assign wr_comm   = wr_fire & wr_mapped & wr_lane0 & (wr_off == `CANIP_OFF_COMM);

   // address ready drops on take and comes back only after the response
   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_awready <= 1'b1;
      else if (s_axi_awvalid && s_axi_awready)
         s_axi_awready <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_awready <= 1'b1;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         wr_addr <= 12'h000;
      else if (s_axi_awvalid && s_axi_awready)
         wr_addr <= s_axi_awaddr;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_wready <= 1'b1;
      else if (s_axi_wvalid && s_axi_wready)
         s_axi_wready <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_wready <= 1'b1;
   end

   // only the low byte lane carries register data
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_data  <= 8'h00;
         wr_lane0 <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         wr_data  <= s_axi_wdata[7:0];
         wr_lane0 <= s_axi_wstrb[0];
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_bvalid <= 1'b0;
      else if (wr_fire)
         s_axi_bvalid <= 1'b1;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_bresp <= `CANIP_RESP_OKAY;
      else if (wr_fire)
         s_axi_bresp <= wr_mapped ? `CANIP_RESP_OKAY : `CANIP_RESP_SLVERR;
   end

   // error state is evaluated from the counters every cycle
   assign live_err[`CANIP_CS_RXWARN] = {1'b0, rx_err_count} >= `CANIP_WARN_LIMIT;
   assign live_err[`CANIP_CS_TXWARN] = tx_err_count >= `CANIP_WARN_LIMIT;
   assign live_err[`CANIP_CS_RXPASS] = {1'b0, rx_err_count} > `CANIP_PASS_LIMIT;
   assign live_err[`CANIP_CS_TXPASS] = tx_err_count > `CANIP_PASS_LIMIT;
   // a 9-bit counter holds up to 511, so any value from 256 up is past 255
   assign live_err[`CANIP_CS_BUSOFF] = tx_err_count > `CANIP_BOFF_LIMIT;
   assign err_changed = (live_err != err_state);

   // accepted frame goes to the buffer if free, otherwise overflows
   assign ovf_event = rx_frame_accepted &
                      {irq_flag_reg[`CANIP_B_RX1], irq_flag_reg[`CANIP_B_RX0]};
   assign wake_event = sleep_mode & irq_enable_reg[`CANIP_B_WAKE] & bus_activity;

   assign flag_set[`CANIP_B_RX0]    = rx_frame_accepted[0] & ~irq_flag_reg[`CANIP_B_RX0];
   assign flag_set[`CANIP_B_RX1]    = rx_frame_accepted[1] & ~irq_flag_reg[`CANIP_B_RX1];
   assign flag_set[`CANIP_B_TX0]    = tx_buf_done[0];
   assign flag_set[`CANIP_B_TX1]    = tx_buf_done[1];
   assign flag_set[`CANIP_B_TX2]    = tx_buf_done[2];
   assign flag_set[`CANIP_B_ERR]    = (|ovf_event) | err_changed;
   assign flag_set[`CANIP_B_WAKE]   = wake_event;
   assign flag_set[`CANIP_B_MSGERR] = msg_error_event;

   // writing zero clears, writing one leaves the flag alone
   assign flag_clr = wr_flag ? ~wr_data : 8'h00;

   genvar gi;
   generate
      for (gi = 0; gi < `CANIP_NSRC; gi = gi + 1)
      begin : g_flag
         // a pending set condition beats a clear in the same cycle
         assign next_flag[gi] = flag_set[gi] |
                                (irq_flag_reg[gi] & ~flag_clr[gi]);
      end
   endgenerate

   always @*
   begin
      next_enable = irq_enable_reg;
      if (wr_enable)
         next_enable = wr_data;
      next_ovf = rx_overflow_bit | ovf_event;
      if (wr_comm)
         next_ovf = ovf_event | (rx_overflow_bit &
                    {wr_data[`CANIP_CS_OVF1], wr_data[`CANIP_CS_OVF0]});
      next_sleep = sleep_mode;
      if (wr_state)
         next_sleep = wr_data[`CANIP_ST_SLEEP];
      if (wake_event)
         next_sleep = 1'b0;
   end

   assign next_pend = next_flag & next_enable;

   // fixed priority, re-evaluated every cycle so a clear exposes the next
   always @*
   begin
      next_code = `CANIP_CODE_NONE;
      if (next_pend[`CANIP_B_ERR])
         next_code = `CANIP_CODE_ERR;
      else if (next_pend[`CANIP_B_WAKE])
         next_code = `CANIP_CODE_WAKE;
      else if (next_pend[`CANIP_B_TX0])
         next_code = `CANIP_CODE_TX0;
      else if (next_pend[`CANIP_B_TX1])
         next_code = `CANIP_CODE_TX1;
      else if (next_pend[`CANIP_B_TX2])
         next_code = `CANIP_CODE_TX2;
      else if (next_pend[`CANIP_B_RX0])
         next_code = `CANIP_CODE_RX0;
      else if (next_pend[`CANIP_B_RX1])
         next_code = `CANIP_CODE_RX1;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         irq_flag_reg <= 8'h00;
      else
         irq_flag_reg <= next_flag;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         irq_enable_reg <= 8'h00;
      else
         irq_enable_reg <= next_enable;
   end

   // previous error state, so a crossing in either direction is seen once
   always @(posedge aclk)
   begin
      if (!aresetn)
         err_state <= 5'h00;
      else
         err_state <= live_err;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         rx_overflow_bit <= 2'h0;
      else
         rx_overflow_bit <= next_ovf;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         sleep_mode <= 1'b0;
      else
         sleep_mode <= next_sleep;
   end

   // code and request come from next values so they track the flags
   always @(posedge aclk)
   begin
      if (!aresetn)
         pending_source_code <= `CANIP_CODE_NONE;
      else
         pending_source_code <= next_code;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |next_pend;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         rx_load <= 2'h0;
      else
         rx_load <= {flag_set[`CANIP_B_RX1], flag_set[`CANIP_B_RX0]};
   end

   assign module_state_reg = {4'h0, sleep_mode, pending_source_code};
   assign comm_status_reg  = {1'b0, rx_overflow_bit, err_state};

   assign rd_off = s_axi_araddr[`CANIP_ADDR_W-1:0];

   always @*
   begin
      rd_byte = 8'h00;
      rd_ok   = (s_axi_araddr[`CANIP_ADDR_HI:`CANIP_ADDR_W] == 8'h00);
      case (rd_off)
         `CANIP_OFF_FLAG:   rd_byte = irq_flag_reg;
         `CANIP_OFF_ENABLE: rd_byte = irq_enable_reg;
         `CANIP_OFF_STATE:  rd_byte = module_state_reg;
         `CANIP_OFF_COMM:   rd_byte = comm_status_reg;
         default:           rd_ok   = 1'b0;
      endcase
   end

   // one read at a time: no new address until the data is taken
   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_arready <= 1'b1;
      else if (s_axi_arvalid && s_axi_arready)
         s_axi_arready <= 1'b0;
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_arready <= 1'b1;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_rvalid <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready)
         s_axi_rvalid <= 1'b1;
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_rdata <= 32'h00000000;
      else if (s_axi_arvalid && s_axi_arready)
         s_axi_rdata <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_rresp <= `CANIP_RESP_OKAY;
      else if (s_axi_arvalid && s_axi_arready)
         s_axi_rresp <= rd_ok ? `CANIP_RESP_OKAY : `CANIP_RESP_SLVERR;
   end

endmodule
`default_nettype wire

// ### core/canip_regs.vh
`ifndef CANIP_REGS_VH
`define CANIP_REGS_VH

// register byte offsets
`define CANIP_OFF_FLAG      4'h0
`define CANIP_OFF_ENABLE    4'h4
`define CANIP_OFF_STATE     4'h8
`define CANIP_OFF_COMM      4'hc
`define CANIP_ADDR_W        4
`define CANIP_ADDR_HI       11

// flag and enable bit positions
`define CANIP_B_RX0         0
`define CANIP_B_RX1         1
`define CANIP_B_TX0         2
`define CANIP_B_TX1         3
`define CANIP_B_TX2         4
`define CANIP_B_ERR         5
`define CANIP_B_WAKE        6
`define CANIP_B_MSGERR      7
`define CANIP_NSRC          8

// module state register fields
`define CANIP_ST_CODE_LO    0
`define CANIP_ST_CODE_HI    2
`define CANIP_ST_SLEEP      3

// comm status register fields
`define CANIP_CS_RXWARN     0
`define CANIP_CS_TXWARN     1
`define CANIP_CS_RXPASS     2
`define CANIP_CS_TXPASS     3
`define CANIP_CS_BUSOFF     4
`define CANIP_CS_OVF0       5
`define CANIP_CS_OVF1       6
`define CANIP_NERRST        5

// pending source codes
`define CANIP_CODE_NONE     3'h0
`define CANIP_CODE_ERR      3'h1
`define CANIP_CODE_WAKE     3'h2
`define CANIP_CODE_TX0      3'h3
`define CANIP_CODE_TX1      3'h4
`define CANIP_CODE_TX2      3'h5
`define CANIP_CODE_RX0      3'h6
`define CANIP_CODE_RX1      3'h7

// error counter limits
`define CANIP_WARN_LIMIT    9'h060
`define CANIP_PASS_LIMIT    9'h07f
`define CANIP_BOFF_LIMIT    9'h0ff

// bus responses
`define CANIP_RESP_OKAY     2'h0
`define CANIP_RESP_SLVERR   2'h2

`endif

// ### verif/canip_properties.sv
`timescale 1ns/100ps
`default_nettype none
module canip_props
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic [1:0] rx_frame_accepted,
   input wire logic [1:0] rx_load,
   input wire logic       bus_activity,
   input wire logic       sleep_mode,
   input wire logic [2:0] pending_source_code,
   input wire logic       irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_code_has_irq: assert property (pending_source_code != 3'h0 |-> irq)
      else $error("code without irq");
   chk_idle_no_code: assert property (!irq |-> pending_source_code == 3'h0)
      else $error("code while idle");
   chk_load_cause: assert property ((rx_load & ~$past(rx_frame_accepted)) == 2'h0)
      else $error("load without accept");
   // a register write may also end sleep, so that edge is excused
   chk_wake_cause: assert property ($fell(sleep_mode) && !s_axi_bvalid |-> $past(bus_activity))
      else $error("sleep ended without activity");
   chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stuck");
   chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid stuck");
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("awready during response");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready during response");
   cover property ($rose(irq));
   cover property (rx_load != 2'h0);
   cover property ($fell(sleep_mode));
endmodule
bind canip_top canip_props i_props
(
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_load(rx_load),
   .rx_frame_accepted(rx_frame_accepted), .bus_activity(bus_activity),
   .sleep_mode(sleep_mode), .pending_source_code(pending_source_code), .irq(irq)
);
`default_nettype wire

// ### verif/canip_host.sv
`timescale 1ns/100ps
`default_nettype none
module canip_host
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       irq,
   input wire logic [2:0] pending_source_code,
   output var logic [2:0] taken_code
);
   logic irq_d;
   // a core reads the code only when the request first rises
   always @(posedge aclk)
   begin
      irq_d <= irq && aresetn;
      if (!aresetn)
         taken_code <= 3'h0;
      else if (irq && !irq_d)
         taken_code <= pending_source_code;
   end
endmodule
`default_nettype wire

// ### verif/test_can_interrupt_prioritizer.sv
`timescale 1ns/100ps
`default_nettype none
module test_can_interrupt_prioritizer;
   localparam int ORD [7] = '{5, 6, 2, 3, 4, 0, 1};
   localparam logic [7:0] RXV [7] = '{8'h5f, 8'h60, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [8:0] TXV [7] = '{9'h000, 9'h000, 9'h000, 9'h060, 9'h080, 9'h100, 9'h000};
   logic        aclk = 1'b0, aresetn = 1'b0, merr = 1'b0, act = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0, rd_d;
   logic [2:0]  txd = 3'h0;
   logic [1:0]  rxa = 2'h0, rsp;
   logic [7:0]  rxc = 8'h00, fl, en, pc;
   logic [8:0]  txc = 9'h000;
   logic [15:0] lf = 16'h003c;
   wire         awready, wready, bvalid, arready, rvalid, irq, sleep;
   wire  [1:0]  bresp, rresp, rxl;
   wire  [2:0]  code, hcode;
   wire  [31:0] rdata;
   int          failures = 0, compares = 0, loads = 0, lb;
   always #12.5 aclk = ~aclk;
   always @(posedge aclk)
      if (rxl[0])
         loads <= loads + 1;
   canip_top i_dut
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(addr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(addr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_buf_done(txd),
      .rx_frame_accepted(rxa), .msg_error_event(merr), .bus_activity(act),
      .rx_err_count(rxc), .tx_err_count(txc), .rx_load(rxl),
      .pending_source_code(code), .sleep_mode(sleep), .irq(irq)
   );
   canip_host i_host
   (
      .aclk(aclk), .aresetn(aresetn), .irq(irq), .pending_source_code(code), .taken_code(hcode)
   );
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // scan from lowest priority so the highest pending source wins
   function automatic logic [2:0] pick(input logic [7:0] f);
      pick = 3'h0;
      for (int i = 6; i >= 0; i--)
         if (f[ORD[i]])
            pick = 3'(i + 1);
   endfunction
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask
   // one address serves both directions, only one transfer is ever open
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n = 0;
      logic done = 1'b0;
      @(posedge aclk);
      addr <= a;
      wdata <= {24'h0, d};
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      while (!done && n < 60)
      begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (arready) arvalid <= 1'b0;
         done = w ? bvalid : rvalid;
      end
      rd_d = rdata;
      rsp = w ? bresp : rresp;
      bready <= 1'b0;
      rready <= 1'b0;
      if (!done)
      begin
         failures++;
         test_done();
      end
   endtask
   task automatic ev(input logic [2:0] t, input logic [1:0] r, input logic m);
      @(posedge aclk);
      txd <= t;
      rxa <= r;
      merr <= m;
      @(posedge aclk);
      txd <= 3'h0;
      rxa <= 2'h0;
      merr <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      acc(0, 12'h004, 8'h00);
      cmp("enable reset", 0, rd_d);
      for (int i = 0; i < 12; i++)
      begin
         lf = nxt(lf);
         en = lf[7:0];
         acc(1, 12'h004, en);
         acc(1, 12'h000, 8'h00);
         ev(lf[10:8], lf[12:11], 1'b0);
         fl = {3'h0, lf[10:8], lf[12:11]};
         acc(0, 12'h000, 8'h00);
         cmp("flags", fl, rd_d);
         cmp("irq", |(fl & en), irq);
         for (int k = 0; k < 7; k++)
         begin
            cmp("code", pick(fl & en), code);
            fl[ORD[k]] = 1'b0;
            acc(1, 12'h000, fl);
         end
         cmp("code idle", 0, code);
      end
      acc(1, 12'h004, 8'h00);
      ev(3'h0, 2'h0, 1'b1);
      acc(0, 12'h000, 8'h00);
      cmp("msg flag", 8'h80, rd_d);
      cmp("msg masked", 0, irq);
      acc(1, 12'h004, 8'h80);
      cmp("msg irq", 1, irq);
      cmp("msg code", 0, code);
      lb = loads;
      acc(1, 12'h000, 8'h00);
      ev(3'h0, 2'h1, 1'b0);
      ev(3'h0, 2'h1, 1'b0);
      acc(0, 12'h00c, 8'h00);
      cmp("overflow", 1, rd_d[5]);
      cmp("loads", lb + 1, loads);
      acc(0, 12'h000, 8'h00);
      cmp("ovf flags", 8'h21, rd_d);
      acc(1, 12'h00c, 8'h00);
      acc(0, 12'h00c, 8'h00);
      cmp("ovf clear", 0, rd_d[5]);
      pc = 8'h00;
      for (int k = 0; k < 7; k++)
      begin
         acc(1, 12'h000, 8'h00);
         rxc <= RXV[k];
         txc <= TXV[k];
         repeat (3) @(posedge aclk);
         fl = {3'h0, TXV[k][8], TXV[k] > 9'h07f, RXV[k] > 8'h7f, TXV[k] >= 9'h060, RXV[k] >= 8'h60};
         acc(0, 12'h00c, 8'h00);
         cmp("comm", fl, rd_d[4:0]);
         acc(0, 12'h000, 8'h00);
         cmp("err flag", fl != pc, rd_d[5]);
         pc = fl;
      end
      acc(1, 12'h000, 8'h00);
      acc(1, 12'h004, 8'h40);
      acc(1, 12'h008, 8'h08);
      cmp("sleep", 1, sleep);
      act <= 1'b1;
      repeat (3) @(posedge aclk);
      cmp("woken", 0, sleep);
      cmp("wake code", 2, code);
      cmp("host code", 2, hcode);
      act <= 1'b0;
      repeat (4) @(posedge aclk);
      cmp("wake held", 1, irq);
      acc(0, 12'h010, 8'h00);
      cmp("bad read resp", 2, rsp);
      cmp("bad read data", 0, rd_d);
      acc(1, 12'h014, 8'hff);
      cmp("bad write resp", 2, rsp);
      test_done();
   end
endmodule
`default_nettype wire
